// ===== hdl/ioxi2c_pkg.sv
`default_nettype none

package ioxi2c_pkg;

    // Address byte layout
    localparam logic [3:0] ADDR_FIXED_HI    = 4'h4;
    localparam int         ADDR_STRAP_LSB   = 1;
    localparam int         BYTE_MSB         = 7;

    // Register selectors (command byte low bits)
    localparam logic [2:0] REG_IN0          = 3'h0;
    localparam logic [2:0] REG_IN1          = 3'h1;
    localparam logic [2:0] REG_OUT0         = 3'h2;
    localparam logic [2:0] REG_OUT1         = 3'h3;
    localparam logic [2:0] REG_POL0         = 3'h4;
    localparam logic [2:0] REG_POL1         = 3'h5;
    localparam logic [2:0] REG_CFG0         = 3'h6;
    localparam logic [2:0] REG_CFG1         = 3'h7;
    localparam int         REG_COUNT        = 8;

    // Reset values
    localparam logic [7:0] RST_OUT          = 8'hff;
    localparam logic [7:0] RST_POL          = 8'h00;
    localparam logic [7:0] RST_CFG          = 8'hff;
    localparam logic [2:0] RST_CMD          = 3'h0;

    // Serial engine states
    typedef enum logic [5:0] {
        IOXI_IDLE = 6'h01,
        IOXI_RECV = 6'h02,
        IOXI_ACK  = 6'h04,
        IOXI_SEND = 6'h08,
        IOXI_MACK = 6'h10,
        IOXI_WAIT = 6'h20
    } ioxi_state_t;

endpackage

`default_nettype wire

// ===== hdl/ioxi2c_regfile.sv
`timescale 1ns/1ps
`default_nettype none

// Small register memory with registered read data
module ioxi2c_regfile (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       arst_n,
    // Write port
    input  wire logic       wr_en,
    input  wire logic [2:0] wr_sel,
    input  wire logic [7:0] wr_data,
    // Read port
    input  wire logic [2:0] rd_sel,
    input  wire logic [7:0] in_low,
    input  wire logic [7:0] in_high,
    output logic      [7:0] rd_data,
    // Register contents for the port logic
    output logic      [7:0] out_low_q,
    output logic      [7:0] out_high_q,
    output logic      [7:0] pol_low_q,
    output logic      [7:0] pol_high_q,
    output logic      [7:0] cfg_low_q,
    output logic      [7:0] cfg_high_q
);

    // Writable registers; input ports ignore writes
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            out_low_q  <= ioxi2c_pkg::RST_OUT;
            out_high_q <= ioxi2c_pkg::RST_OUT;
            pol_low_q  <= ioxi2c_pkg::RST_POL;
            pol_high_q <= ioxi2c_pkg::RST_POL;
            cfg_low_q  <= ioxi2c_pkg::RST_CFG;
            cfg_high_q <= ioxi2c_pkg::RST_CFG;
        end else if (wr_en) begin
            case (wr_sel)
                ioxi2c_pkg::REG_OUT0: out_low_q  <= wr_data;
                ioxi2c_pkg::REG_OUT1: out_high_q <= wr_data;
                ioxi2c_pkg::REG_POL0: pol_low_q  <= wr_data;
                ioxi2c_pkg::REG_POL1: pol_high_q <= wr_data;
                ioxi2c_pkg::REG_CFG0: cfg_low_q  <= wr_data;
                ioxi2c_pkg::REG_CFG1: cfg_high_q <= wr_data;
                default: ;
            endcase
        end
    end

    // Registered read mux
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_data <= 8'h00;
        end else begin
            case (rd_sel)
                ioxi2c_pkg::REG_IN0:  rd_data <= in_low ^ pol_low_q;
                ioxi2c_pkg::REG_IN1:  rd_data <= in_high ^ pol_high_q;
                ioxi2c_pkg::REG_OUT0: rd_data <= out_low_q;
                ioxi2c_pkg::REG_OUT1: rd_data <= out_high_q;
                ioxi2c_pkg::REG_POL0: rd_data <= pol_low_q;
                ioxi2c_pkg::REG_POL1: rd_data <= pol_high_q;
                ioxi2c_pkg::REG_CFG0: rd_data <= cfg_low_q;
                default:              rd_data <= cfg_high_q;
            endcase
        end
    end

endmodule

`default_nettype wire

// ===== hdl/ioxi2c_target.sv
`timescale 1ns/1ps
`default_nettype none

module ioxi2c_target (
    // Clock and power-on reset
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    // Serial bus pins
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    // Address straps
    input  wire logic        addr_strap_bit0,
    input  wire logic        addr_strap_bit1,
    input  wire logic        addr_strap_bit2,
    // Port pins
    input  wire logic [7:0]  port_low_pins,
    input  wire logic [7:0]  port_high_pins,
    output logic      [15:0] port_drive_q,
    output logic      [15:0] port_oe_q,
    output logic      [1:0]  int_pending_q
);

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers: two flops before any logic
    logic [1:0]  scl_s, sda_s;
    logic [15:0] pin_s1, pin_s2;
    logic [2:0]  strap_s1, strap_s2, strap_q;
    logic        scl_d1;
    logic        sda_d1;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            scl_s    <= 2'h3;
            sda_s    <= 2'h3;
            pin_s1   <= 16'h0000;
            pin_s2   <= 16'h0000;
            strap_s1 <= 3'h0;
            strap_s2 <= 3'h0;
            scl_d1   <= 1'b1;
            sda_d1   <= 1'b1;
        end else begin
            scl_s    <= {scl_s[0], scl_in};
            sda_s    <= {sda_s[0], sda_in};
            pin_s1   <= {port_high_pins, port_low_pins};
            pin_s2   <= pin_s1;
            strap_s1 <= {addr_strap_bit2, addr_strap_bit1, addr_strap_bit0};
            strap_s2 <= strap_s1;
            scl_d1   <= scl_s[1];
            sda_d1   <= sda_s[1];
        end
    end

    // Strap register follows the synchronised straps every cycle after reset release; straps must not change later
    logic strap_done_q;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            strap_done_q <= 1'b0;
            strap_q      <= 3'h0;
        end else begin
            strap_done_q <= 1'b1;
            strap_q      <= strap_s2;
        end
    end

    // Bus events
    logic scl_rise, scl_fall, start_ev, stop_ev;
    assign scl_rise = scl_s[1] & ~scl_d1;
    assign scl_fall = ~scl_s[1] & scl_d1;
    assign start_ev = scl_s[1] & scl_d1 & sda_d1 & ~sda_s[1];
    assign stop_ev  = scl_s[1] & scl_d1 & ~sda_d1 & sda_s[1];

    ////////////////////////////////////////////////////////////////////////
    // Serial engine state
    ioxi2c_pkg::ioxi_state_t state_q;
    logic [7:0] shift_q;
    logic [3:0] bitcnt_q;
    logic [1:0] phase_q;    // 0 address, 1 command, 2 data
    logic       rw_q;
    logic [2:0] cmd_q;      // Stored pointer
    logic [2:0] cur_q;      // Register now being accessed
    logic       ack_drv_q;
    logic       wr_en_q;
    logic [7:0] rd_data;
    logic       strobe_q;   // Data-latch pulse at ack rising edge
    logic       addr_hit;

    assign addr_hit = (shift_q[7:4] == ioxi2c_pkg::ADDR_FIXED_HI)
                    && (shift_q[3:1] == strap_q) && strap_done_q;

    // Pair alternation helper
    function automatic logic [2:0] pair_other(input logic [2:0] sel);
        pair_other = {sel[2:1], ~sel[0]};
    endfunction

    // Main serial state machine
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q   <= ioxi2c_pkg::IOXI_IDLE;
            shift_q   <= 8'h00;
            bitcnt_q  <= 4'h0;
            phase_q   <= 2'h0;
            rw_q      <= 1'b0;
            cmd_q     <= ioxi2c_pkg::RST_CMD;
            cur_q     <= ioxi2c_pkg::RST_CMD;
            ack_drv_q <= 1'b0;
            wr_en_q   <= 1'b0;
            strobe_q  <= 1'b0;
        end else begin
            wr_en_q  <= 1'b0;
            strobe_q <= 1'b0;
            if (start_ev) begin
                // Only a restart past the address phase stores the pointer
                if (state_q != ioxi2c_pkg::IOXI_IDLE && phase_q != 2'h0)
                    cmd_q <= cur_q;
                state_q   <= ioxi2c_pkg::IOXI_RECV;
                bitcnt_q  <= 4'h0;
                phase_q   <= 2'h0;
                ack_drv_q <= 1'b0;
            end else if (stop_ev) begin
                state_q   <= ioxi2c_pkg::IOXI_IDLE;
                ack_drv_q <= 1'b0;
            end else begin
                case (state_q)
                    ioxi2c_pkg::IOXI_RECV: begin
                        if (scl_rise) begin
                            shift_q  <= {shift_q[6:0], sda_s[1]};
                            bitcnt_q <= bitcnt_q + 4'h1;
                        end
                        if (scl_fall && bitcnt_q == 4'h8) begin
                            bitcnt_q <= 4'h0;
                            state_q  <= ioxi2c_pkg::IOXI_ACK;
                            if (phase_q == 2'h0) begin
                                if (addr_hit) begin
                                    ack_drv_q <= 1'b1;
                                    rw_q      <= shift_q[0];
                                    cur_q     <= cmd_q;
                                end else begin
                                    state_q <= ioxi2c_pkg::IOXI_WAIT;
                                end
                            end else begin
                                ack_drv_q <= 1'b1;
                                if (phase_q == 2'h1) begin
                                    cmd_q <= shift_q[2:0];
                                    cur_q <= shift_q[2:0];
                                end
                            end
                        end
                    end
                    ioxi2c_pkg::IOXI_ACK: begin
                        if (scl_rise) begin
                            strobe_q <= 1'b1;
                            if (phase_q == 2'h2 && !rw_q)
                                wr_en_q <= 1'b1;
                        end
                        if (scl_fall) begin
                            ack_drv_q <= 1'b0;
                            if (phase_q == 2'h0 && rw_q) begin
                                phase_q <= 2'h2;
                                shift_q <= rd_data;
                                state_q <= ioxi2c_pkg::IOXI_SEND;
                            end else begin
                                if (phase_q == 2'h2 && !rw_q)
                                    cur_q <= pair_other(cur_q);
                                phase_q <= (phase_q == 2'h0) ? 2'h1 : 2'h2;
                                state_q <= ioxi2c_pkg::IOXI_RECV;
                            end
                        end
                    end
                    ioxi2c_pkg::IOXI_SEND: begin
                        if (scl_fall) begin
                            shift_q  <= {shift_q[6:0], 1'b0};
                            bitcnt_q <= bitcnt_q + 4'h1;
                            if (bitcnt_q == 4'h7) begin
                                bitcnt_q <= 4'h0;
                                state_q  <= ioxi2c_pkg::IOXI_MACK;
                            end
                        end
                    end
                    ioxi2c_pkg::IOXI_MACK: begin
                        if (scl_rise) begin
                            strobe_q <= 1'b1;
                            if (sda_s[1])
                                state_q <= ioxi2c_pkg::IOXI_WAIT;
                            else
                                cur_q <= pair_other(cur_q);
                        end
                    end
                    ioxi2c_pkg::IOXI_WAIT: begin
                        ack_drv_q <= 1'b0;
                    end
                    default: state_q <= ioxi2c_pkg::IOXI_IDLE;
                endcase
                // Load next read byte after the controller's ack
                if (state_q == ioxi2c_pkg::IOXI_MACK && scl_fall) begin
                    shift_q <= rd_data;
                    state_q <= ioxi2c_pkg::IOXI_SEND;
                end
            end
        end
    end

    // Data line drive, registered; open-drain so only low is driven
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sda_oe  <= 1'b0;
            sda_out <= 1'b0;
        end else begin
            sda_out <= 1'b0;
            sda_oe  <= ack_drv_q
                     | (state_q == ioxi2c_pkg::IOXI_SEND && !shift_q[7]);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register memory
    logic [7:0] out_lo, out_hi, pol_lo, pol_hi, cfg_lo, cfg_hi;
    logic [15:0] in_snap_q;

    ioxi2c_regfile i_ioxi2c_regfile (
        .core_clk   (core_clk),
        .arst_n     (arst_n),
        .wr_en      (wr_en_q),
        .wr_sel     (cur_q),
        .wr_data    (shift_q),
        .rd_sel     (cur_q),
        .in_low     (in_snap_q[7:0]),
        .in_high    (in_snap_q[15:8]),
        .rd_data    (rd_data),
        .out_low_q  (out_lo),
        .out_high_q (out_hi),
        .pol_low_q  (pol_lo),
        .pol_high_q (pol_hi),
        .cfg_low_q  (cfg_lo),
        .cfg_high_q (cfg_hi)
    );

    // Port drivers follow output and configuration registers
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            port_drive_q <= {ioxi2c_pkg::RST_OUT, ioxi2c_pkg::RST_OUT};
            port_oe_q    <= 16'h0000;
        end else begin
            port_drive_q <= {out_hi, out_lo};
            port_oe_q    <= ~{cfg_hi, cfg_lo};
        end
    end

    // Per-port input snapshot, refreshed during warm-up and at that port's read ack
    logic [1:0]  rd_clr;
    logic [1:0]  warm_q;    // Counts out the pin synchroniser after reset
    logic [15:0] cfg_all;
    assign rd_clr[0] = strobe_q && rw_q && cur_q == ioxi2c_pkg::REG_IN0;
    assign rd_clr[1] = strobe_q && rw_q && cur_q == ioxi2c_pkg::REG_IN1;
    assign cfg_all   = {cfg_hi, cfg_lo};

    // Snapshot tracks pins until the synchroniser is full: no false flag
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            warm_q        <= 2'h0;
            in_snap_q     <= 16'h0000;
            int_pending_q <= 2'h0;
        end else begin
            if (warm_q != 2'h3)
                warm_q <= warm_q + 2'h1;
            for (int p = 0; p < 2; p++) begin
                if (warm_q != 2'h3 || rd_clr[p]) begin
                    in_snap_q[p*8 +: 8] <= pin_s2[p*8 +: 8];
                    int_pending_q[p]    <= 1'b0;
                end else if (|((pin_s2[p*8 +: 8] ^ in_snap_q[p*8 +: 8]) & cfg_all[p*8 +: 8]))
                    int_pending_q[p] <= 1'b1;
                else
                    int_pending_q[p] <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_nomatch_quiet: assert property (@(posedge core_clk) disable iff (!arst_n)
        state_q == ioxi2c_pkg::IOXI_WAIT && $past(state_q) == ioxi2c_pkg::IOXI_WAIT
        |-> !ack_drv_q) else $error("drive while ignoring");
    a_stop_idle: assert property (@(posedge core_clk) disable iff (!arst_n)
        stop_ev && !start_ev |=> state_q == ioxi2c_pkg::IOXI_IDLE)
        else $error("stop not honoured");
    a_write_at_ack: assert property (@(posedge core_clk) disable iff (!arst_n)
        wr_en_q |-> $past(state_q) == ioxi2c_pkg::IOXI_ACK && !rw_q)
        else $error("write outside ack");
    a_nack_release: assert property (@(posedge core_clk) disable iff (!arst_n)
        state_q == ioxi2c_pkg::IOXI_WAIT ##1 state_q == ioxi2c_pkg::IOXI_WAIT
        |-> !sda_oe) else $error("sda held after nack");
    a_read_clears: assert property (@(posedge core_clk) disable iff (!arst_n)
        rd_clr[0] |=> !int_pending_q[0]) else $error("int not cleared");
    a_pair_alt: assert property (@(posedge core_clk) disable iff (!arst_n)
        state_q == ioxi2c_pkg::IOXI_MACK && scl_rise && !sda_s[1] && !start_ev && !stop_ev
        |=> cur_q[2:1] == $past(cur_q[2:1]) && cur_q[0] != $past(cur_q[0]))
        else $error("pair not alternated");
    a_cmd_store: assert property (@(posedge core_clk) disable iff (!arst_n)
        state_q == ioxi2c_pkg::IOXI_RECV && phase_q == 2'h1 && scl_fall
        && bitcnt_q == 4'h8 && !start_ev && !stop_ev
        |=> cmd_q == $past(shift_q[2:0])) else $error("command not stored");
    a_addr_ack: assert property (@(posedge core_clk) disable iff (!arst_n)
        state_q == ioxi2c_pkg::IOXI_RECV && phase_q == 2'h0 && scl_fall
        && bitcnt_q == 4'h8 && addr_hit && !start_ev && !stop_ev
        |=> ack_drv_q ##1 sda_oe) else $error("address not acked");
    c_write: cover property (@(posedge core_clk) disable iff (!arst_n) wr_en_q);
    c_read: cover property (@(posedge core_clk) disable iff (!arst_n)
        state_q == ioxi2c_pkg::IOXI_SEND);
    c_nack: cover property (@(posedge core_clk) disable iff (!arst_n)
        state_q == ioxi2c_pkg::IOXI_MACK ##1 state_q == ioxi2c_pkg::IOXI_WAIT);

endmodule

`default_nettype wire

// ===== verification/ioxi2c_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none

// Bus controller model: paces SCL, pulls SDA, resolves the open-drain line
module ioxi2c_ctrl_model (
    // Pacing clock
    input  wire logic core_clk,
    // Target data pin driver
    input  wire logic sda_out,
    input  wire logic sda_oe,
    // Resolved bus lines
    output logic      scl,
    output logic      sda
);
    logic pull_q;

    // Pull-up: a released line reads high
    assign sda = !(pull_q || (sda_oe && !sda_out));

    // Bus idle, both lines high
    initial begin
        scl    = 1'b1;
        pull_q = 1'b0;
    end

    // Wait n falling edges; one bit spans 8 cycles, 160 ns
    task automatic tk(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    // Start from idle, or repeated start from a low clock
    task automatic start();
        if (!scl) begin
            pull_q = 1'b0;
            tk(2);
            scl = 1'b1;
            tk(2);
        end
        pull_q = 1'b1;
        tk(2);
        scl = 1'b0;
        tk(2);
    endtask

    // One clock pulse; b=1 releases SDA, r is the line one cycle before SCL falls
    task automatic bit_io(input logic b, output logic r);
        pull_q = !b;
        tk(2);
        scl = 1'b1;
        tk(3);
        r = sda;
        tk(1);
        scl = 1'b0;
        tk(2);
    endtask

    // Byte out MSB first, then sample the target's acknowledge
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = !r;
    endtask

    // Byte in MSB first; acknowledge only when more bytes are wanted
    task automatic rbyte(input logic more, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, d[i]);
        end
        bit_io(!more, r);
    endtask

    // Stop condition, bus left idle
    task automatic stop();
        pull_q = 1'b1;
        tk(2);
        scl = 1'b1;
        tk(2);
        pull_q = 1'b0;
        tk(4);
    endtask
endmodule

`default_nettype wire

// ===== verification/tb_io_expander_i2c_target_access.sv
`timescale 1ns/1ps
`default_nettype none

module tb_io_expander_i2c_target_access;
    localparam logic [2:0] STRAP = 3'h5;
    localparam logic [7:0] AW    = {ioxi2c_pkg::ADDR_FIXED_HI, STRAP, 1'b0};
    localparam logic [7:0] AR    = {ioxi2c_pkg::ADDR_FIXED_HI, STRAP, 1'b1};

    logic        core_clk;
    logic        arst_n;
    logic        scl;
    logic        sda;
    logic        sda_out;
    logic        sda_oe;
    logic [7:0]  port_low_pins;
    logic [7:0]  port_high_pins;
    logic [15:0] port_drive_q;
    logic [15:0] port_oe_q;
    logic [1:0]  int_pending_q;
    logic [7:0]  exp_reg [8];
    logic [7:0]  b;
    logic        ack;
    logic        watch;
    int          n_mismatch;
    int          cmp_count;
    int          oe_seen;

    ioxi2c_target i_ioxi2c_target (.core_clk(core_clk), .arst_n(arst_n), .scl_in(scl),
        .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap_bit0(STRAP[0]),
        .addr_strap_bit1(STRAP[1]), .addr_strap_bit2(STRAP[2]),
        .port_low_pins(port_low_pins), .port_high_pins(port_high_pins),
        .port_drive_q(port_drive_q), .port_oe_q(port_oe_q), .int_pending_q(int_pending_q));

    ioxi2c_ctrl_model i_ioxi2c_ctrl_model (.core_clk(core_clk), .sda_out(sda_out),
        .sda_oe(sda_oe), .scl(scl), .sda(sda));

    ////////////////////////////////////////////////////////////////////////////////
    // Clock, watchdog, drive monitor
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    initial begin
        #400us;
        n_mismatch++;
        wrap_up();
    end

    always @(posedge core_clk) begin
        if (watch && sda_oe) oe_seen++;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] want);
        cmp_count++;
        if (got !== want) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, want);
        end
    endtask

    // Expected read value of a register, polarity applied to inputs
    function automatic logic [7:0] ev(input int r);
        if (r == 0) return port_low_pins ^ exp_reg[4];
        if (r == 1) return port_high_pins ^ exp_reg[5];
        return exp_reg[r];
    endfunction

    task automatic do_reset();
        arst_n = 1'b0;
        repeat (3) @(negedge core_clk);
        arst_n = 1'b1;
        repeat (6) @(negedge core_clk);
        exp_reg[2] = ioxi2c_pkg::RST_OUT;
        exp_reg[3] = ioxi2c_pkg::RST_OUT;
        exp_reg[4] = ioxi2c_pkg::RST_POL;
        exp_reg[5] = ioxi2c_pkg::RST_POL;
        exp_reg[6] = ioxi2c_pkg::RST_CFG;
        exp_reg[7] = ioxi2c_pkg::RST_CFG;
        chk(port_drive_q, 16'hffff);
        chk(port_oe_q, 16'h0000);
        chk({13'h0000, int_pending_q, sda_oe}, 16'h0000);
    endtask

    task automatic head(input logic [7:0] a);
        i_ioxi2c_ctrl_model.start();
        i_ioxi2c_ctrl_model.wbyte(a, ack);
        chk(ack, 1'b1);
    endtask

    // Write n bytes after a command byte
    task automatic wr(input logic [2:0] cmd, input logic [15:0] d, input int n);
        int r;
        r = cmd;
        head(AW);
        i_ioxi2c_ctrl_model.wbyte({5'h00, cmd}, ack);
        chk(ack, 1'b1);
        for (int k = 0; k < n; k++) begin
            i_ioxi2c_ctrl_model.wbyte(d[8*k +: 8], ack);
            chk(ack, 1'b1);
            if (r > 1) exp_reg[r] = d[8*k +: 8];
            r = r ^ 1;
        end
        i_ioxi2c_ctrl_model.stop();
    endtask

    // Read n bytes; cmd below zero skips the command phase
    task automatic rd(input int cmd, input int first, input int n);
        int r;
        r = first;
        if (cmd >= 0) begin
            head(AW);
            i_ioxi2c_ctrl_model.wbyte(8'(cmd), ack);
            chk(ack, 1'b1);
        end
        head(AR);
        for (int k = 0; k < n; k++) begin
            i_ioxi2c_ctrl_model.rbyte(k < n - 1, b);
            chk(b, ev(r));
            r = r ^ 1;
        end
        i_ioxi2c_ctrl_model.tk(4);
        chk(sda_oe, 1'b0);
        i_ioxi2c_ctrl_model.stop();
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_write_read();
        wr(3'h2, 16'ha55a, 2);
        chk(port_drive_q, {8'ha5, 8'h5a});
        wr(3'h7, 16'h000f, 2);
        chk(port_oe_q, {~exp_reg[7], ~exp_reg[6]});
        wr(3'h4, 16'h0ff0, 2);
        wr(3'h0, 16'h7777, 2);
        for (int c = 0; c < 8; c++) begin
            rd(c, c, 3);
        end
        $display("test write_read finished");
    endtask

    task automatic t_restart();
        head(AW);
        i_ioxi2c_ctrl_model.wbyte(8'h01, ack);
        head(AR);
        i_ioxi2c_ctrl_model.rbyte(1'b1, b);
        chk(b, ev(1));
        head(AR);
        i_ioxi2c_ctrl_model.rbyte(1'b0, b);
        chk(b, ev(0));
        i_ioxi2c_ctrl_model.stop();
        rd(-1, 0, 2);
        $display("test restart finished");
    endtask

    task automatic t_foreign();
        oe_seen = 0;
        watch = 1'b1;
        i_ioxi2c_ctrl_model.start();
        i_ioxi2c_ctrl_model.wbyte(AW ^ 8'h02, ack);
        chk(ack, 1'b0);
        i_ioxi2c_ctrl_model.wbyte(8'h02, ack);
        i_ioxi2c_ctrl_model.wbyte(8'h00, ack);
        i_ioxi2c_ctrl_model.stop();
        watch = 1'b0;
        chk(16'(oe_seen), 16'h0000);
        chk(port_drive_q, {exp_reg[3], exp_reg[2]});
        $display("test foreign finished");
    endtask

    task automatic t_stop_mid();
        head(AW);
        i_ioxi2c_ctrl_model.wbyte(8'h02, ack);
        for (int i = 0; i < 4; i++) begin
            i_ioxi2c_ctrl_model.bit_io(1'b0, ack);
        end
        i_ioxi2c_ctrl_model.stop();
        chk(port_drive_q, {exp_reg[3], exp_reg[2]});
        rd(-1, 2, 1);
        $display("test stop_mid finished");
    endtask

    task automatic t_change();
        rd(1, 1, 2);
        chk(int_pending_q, 2'b00);
        // Low port is all outputs here, high port inputs on its low nibble
        port_low_pins = 8'h5c;
        port_high_pins = 8'hc2;
        repeat (10) @(negedge core_clk);
        chk(int_pending_q, 2'b10);
        rd(-1, 1, 1);
        chk(int_pending_q, 2'b00);
        $display("test change finished");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        arst_n = 1'b0;
        watch = 1'b0;
        n_mismatch = 0;
        cmp_count = 0;
        oe_seen = 0;
        port_low_pins = 8'h3c;
        port_high_pins = 8'hc5;
        do_reset();
        $display("test reset finished");
        t_write_read();
        t_restart();
        t_foreign();
        t_stop_mid();
        t_change();
        do_reset();
        $display("test second reset finished");
        wrap_up();
    end
endmodule

`default_nettype wire
